// File: logic/sram_port_pkg.sv
// constants shared by the burst sram port and its address generator
`default_nettype none
package sram_port_pkg;
   localparam int ADDR_W = 15;
   localparam int DATA_W = 32;
   localparam int LANE_W = 8;
   localparam int BURST_W = 2;
   localparam int WORDS = 32768;
   localparam logic [BURST_W-1:0] BURST_START = 2'h0;
   localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
   localparam logic RST_ACTIVE = 1'b0;
   localparam logic RST_OE_N = 1'b1;
   localparam logic RST_POWER_DOWN = 1'b1;
endpackage
`default_nettype wire

// File: logic/burst_addr_gen.sv
// low address bits of a burst from the loaded bits and the burst count
`default_nettype none
module burst_addr_gen (
   input wire logic [sram_port_pkg::BURST_W-1:0] base_i,
   input wire logic [sram_port_pkg::BURST_W-1:0] count_i,
   input wire logic interleaved_i,
   output logic [sram_port_pkg::BURST_W-1:0] low_o
);
   // both orders stay inside the four-word group, no carry upward
   always_comb begin
      if (interleaved_i) begin
         low_o = base_i ^ count_i;
      end else begin
         low_o = base_i + count_i;
      end
   end
endmodule
`default_nettype wire

// File: logic/sync_burst_sram_port.sv
// synchronous 32k x 32 burst static ram port with burst counter and output stage
`default_nettype none
module sync_burst_sram_port #(
   parameter int ADDR_W = sram_port_pkg::ADDR_W,
   parameter int DATA_W = sram_port_pkg::DATA_W
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [ADDR_W-1:0] word_addr_i,
   input wire logic [DATA_W-1:0] data_in_i,
   input wire logic select_primary_n_i,
   input wire logic select_expand_high_i,
   input wire logic select_expand_low_n_i,
   input wire logic addr_strobe_proc_i,
   input wire logic addr_strobe_ctrl_i,
   input wire logic burst_advance_n_i,
   input wire logic [DATA_W/sram_port_pkg::LANE_W-1:0] lane_write_n_i,
   input wire logic lane_write_gate_n_i,
   input wire logic global_write_n_i,
   input wire logic output_drive_n_i,
   input wire logic sleep_request_i,
   input wire logic burst_order_sel_i,
   input wire logic output_stage_sel_i,
   output logic [DATA_W-1:0] data_out_o,
   output logic data_oe_n_o,
   output logic power_down_o
);
   localparam int LANES = DATA_W / sram_port_pkg::LANE_W;
   localparam int BW = sram_port_pkg::BURST_W;
   localparam int DEPTH = 2 ** ADDR_W;

   initial begin
      if (DATA_W % sram_port_pkg::LANE_W != 0 || ADDR_W <= BW) begin
         $error("sync_burst_sram_port: unsupported ADDR_W or DATA_W");
      end
   end

   logic [DATA_W-1:0] mem [DEPTH];

   // sleep is asynchronous to the bus clock
   logic sleep_meta;
   logic sleep_sync;

   logic active;
   logic [ADDR_W-1:BW] addr_hi;
   logic [BW-1:0] addr_base;
   logic [BW-1:0] burst_cnt;
   logic read_q;
   logic [DATA_W-1:0] pipe_word;

   logic proc_take;
   logic ctrl_take;
   logic expand_ok;
   logic load;
   logic load_ok;
   logic next_active;
   logic [ADDR_W-1:BW] next_hi;
   logic [BW-1:0] next_base;
   logic [BW-1:0] next_cnt;
   logic [BW-1:0] next_low;
   logic [ADDR_W-1:0] next_addr;
   logic [LANES-1:0] lanes_wr;
   logic lane_any_low;
   logic is_write;
   logic is_read;
   logic [DATA_W-1:0] flow_word;
   logic drive;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sleep_meta <= 1'b0;
         sleep_sync <= 1'b0;
      end else begin
         sleep_meta <= sleep_request_i;
         sleep_sync <= sleep_meta;
      end
   end

   // strobe and select decode, all taken at the same rising edge
   always_comb begin
      expand_ok = select_expand_high_i & ~select_expand_low_n_i;
      proc_take = ~addr_strobe_proc_i & ~select_primary_n_i;
      ctrl_take = ~addr_strobe_ctrl_i & ~proc_take;
      load = proc_take | ctrl_take;
      if (proc_take) begin
         load_ok = expand_ok;
      end else begin
         load_ok = expand_ok & ~select_primary_n_i;
      end
      if (sleep_sync) begin
         next_active = 1'b0;
      end else if (load) begin
         next_active = load_ok;
      end else begin
         next_active = active;
      end
      if (load) begin
         next_hi = word_addr_i[ADDR_W-1:BW];
         next_base = word_addr_i[BW-1:0];
         next_cnt = sram_port_pkg::BURST_START;
      end else begin
         next_hi = addr_hi;
         next_base = addr_base;
         if (active & ~burst_advance_n_i) begin
            next_cnt = burst_cnt + sram_port_pkg::BURST_STEP;
         end else begin
            next_cnt = burst_cnt;
         end
      end
   end

   burst_addr_gen u_burst_addr (
      .base_i(next_base),
      .count_i(next_cnt),
      .interleaved_i(burst_order_sel_i),
      .low_o(next_low)
   );

   always_comb begin
      next_addr = {next_hi, next_low};
      if (~global_write_n_i) begin
         lanes_wr = '1;
      end else if (~lane_write_gate_n_i) begin
         lanes_wr = ~lane_write_n_i;
      end else begin
         lanes_wr = '0;
      end
      lane_any_low = |(~lane_write_n_i);
      // the processor strobe cycle never writes the array; its write comes a cycle later
      is_write = next_active & ~proc_take & (|lanes_wr);
      is_read = next_active & ~is_write;
      flow_word = mem[next_addr];
      drive = ~output_drive_n_i & ~lane_any_low & ~sleep_sync;
   end

   // writes finish at the capturing edge, nothing held afterwards
   always_ff @(posedge clk_i) begin
      for (int l = 0; l < LANES; l++) begin
         if (is_write & lanes_wr[l]) begin
            mem[next_addr][l*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W] <=
               data_in_i[l*sram_port_pkg::LANE_W +: sram_port_pkg::LANE_W];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         active <= sram_port_pkg::RST_ACTIVE;
         burst_cnt <= sram_port_pkg::BURST_START;
         addr_hi <= '0;
         addr_base <= '0;
      end else begin
         active <= next_active;
         burst_cnt <= next_cnt;
         addr_hi <= next_hi;
         addr_base <= next_base;
      end
   end

   // array is read after the previous edge wrote it, so pass-through needs no bypass
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         read_q <= 1'b0;
         pipe_word <= '0;
         data_out_o <= '0;
      end else begin
         read_q <= is_read;
         pipe_word <= flow_word;
         if (output_stage_sel_i) begin
            data_out_o <= pipe_word;
         end else begin
            data_out_o <= flow_word;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         data_oe_n_o <= sram_port_pkg::RST_OE_N;
         power_down_o <= sram_port_pkg::RST_POWER_DOWN;
      end else begin
         data_oe_n_o <= ~(drive & (output_stage_sel_i ? read_q : is_read));
         power_down_o <= sleep_sync | ~next_active;
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   logic [ADDR_W-1:0] cur_addr;
   assign cur_addr = {addr_hi, (burst_order_sel_i ? (addr_base ^ burst_cnt)
                                                   : (addr_base + burst_cnt))};

   chk_addr_capture: assert property (
      load && !sleep_sync |=> cur_addr == $past(word_addr_i))
      else $error("loaded address not captured");
   chk_linear_step: assert property (
      active && !load && !burst_advance_n_i && !burst_order_sel_i
      && $stable(burst_order_sel_i) ##1 !burst_order_sel_i
      |-> cur_addr[BW-1:0] == $past(cur_addr[BW-1:0]) + 2'h1
      && cur_addr[ADDR_W-1:BW] == $past(cur_addr[ADDR_W-1:BW]))
      else $error("linear burst step wrong");
   chk_interleave: assert property (
      active && burst_order_sel_i && burst_cnt == 2'h3
      |-> cur_addr[BW-1:0] == ~addr_base)
      else $error("interleaved fourth address wrong");
   chk_wait_hold: assert property (
      active && !load && burst_advance_n_i && !sleep_sync
      ##1 $stable(burst_order_sel_i) |-> $stable(cur_addr))
      else $error("wait state moved the address");
   chk_lane_off: assert property (
      |(~lane_write_n_i) |=> data_oe_n_o)
      else $error("drivers on while a lane write enable is low");
   chk_oe_release: assert property (
      output_drive_n_i |=> data_oe_n_o)
      else $error("drivers on with output_drive_n high");
   chk_proc_ignored: assert property (
      !addr_strobe_proc_i && select_primary_n_i && addr_strobe_ctrl_i
      && !sleep_sync |=> active == $past(active) && addr_hi == $past(addr_hi))
      else $error("processor strobe honoured with primary select high");
   chk_proc_read: assert property (
      proc_take |-> !is_write)
      else $error("processor strobe cycle wrote the array");
   chk_global_write: assert property (
      is_write && !global_write_n_i |=> mem[$past(next_addr)] == $past(data_in_i))
      else $error("global write did not store all lanes");
   chk_pipe_delay: assert property (
      output_stage_sel_i && $past(output_stage_sel_i) |-> data_out_o == $past(flow_word, 2))
      else $error("pipelined data not one clock later");
   chk_sleep_down: assert property (
      sleep_sync |=> power_down_o && !active && data_oe_n_o)
      else $error("sleep did not power down");

   cov_linear_burst: cover property (
      load && load_ok && !burst_order_sel_i ##1 !burst_advance_n_i [*3]);
   cov_pipe_read: cover property (
      output_stage_sel_i && is_read && drive ##1 output_stage_sel_i ##1 !data_oe_n_o);
   cov_write_then_read: cover property (is_write ##1 is_read && drive);
   cov_deselect: cover property (load && !load_ok);
endmodule
`default_nettype wire

// File: sim/bus_master_model.sv
// bus master model: drives one bus cycle per clock into the sram port
`default_nettype none
module bus_master_model (
   input wire logic clk_i,
   output logic [14:0] word_addr_o,
   output logic [31:0] data_o,
   output logic proc_n_o,
   output logic ctrl_n_o,
   output logic adv_n_o,
   output logic [3:0] lane_n_o,
   output logic gate_n_o,
   output logic glob_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      word_addr_o = 15'h0000;
      data_o = 32'h0;
      {proc_n_o, ctrl_n_o, adv_n_o, lane_n_o, gate_n_o, glob_n_o} = 9'h1ff;
   end
   // signals change just after an edge and stand until the next one
   task automatic present(input logic p_n, c_n, v_n, input logic [3:0] l_n,
      input logic g_n, w_n, input logic [14:0] a, input logic [31:0] d);
      @(posedge clk_i);
      proc_n_o <= p_n;
      ctrl_n_o <= c_n;
      adv_n_o <= v_n;
      lane_n_o <= l_n;
      gate_n_o <= g_n;
      glob_n_o <= w_n;
      word_addr_o <= a;
      data_o <= d;
   endtask
   // no new address: unused lines toggle so stale values never pass as valid
   task automatic idle(input logic v_n);
      present(1'b1, 1'b1, v_n, 4'hf, 1'b1, 1'b1, ~word_addr_o, ~data_o);
   endtask
   task automatic proc_write(input logic [14:0] a, input logic [31:0] d);
      present(1'b0, 1'b1, 1'b1, 4'hf, 1'b1, 1'b1, a, ~d);
      present(1'b1, 1'b1, 1'b1, 4'h0, 1'b0, 1'b1, ~a, d);
   endtask
endmodule
`default_nettype wire

// File: sim/sync_burst_sram_port_tb.sv
// self-checking bench for the burst sram port
`default_nettype none
module sync_burst_sram_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic sel_n = 1'b1, exp_hi = 1'b0, exp_lo_n = 1'b1, drive_n = 1'b0;
   logic sleep = 1'b0, order = 1'b0, stage = 1'b0;
   logic [14:0] addr;
   logic [31:0] wdata, data_out_o;
   logic proc_n, ctrl_n, adv_n, gate_n, glob_n, data_oe_n_o, power_down_o;
   logic [3:0] lane_n;
   int miscompares = 0;
   int comparisons = 0;
   always #5 clk_i = ~clk_i;
   bus_master_model master (.clk_i(clk_i), .word_addr_o(addr), .data_o(wdata),
      .proc_n_o(proc_n), .ctrl_n_o(ctrl_n), .adv_n_o(adv_n), .lane_n_o(lane_n),
      .gate_n_o(gate_n), .glob_n_o(glob_n));
   sync_burst_sram_port dut (.clk_i(clk_i), .reset_i(reset_i), .word_addr_i(addr),
      .data_in_i(wdata), .select_primary_n_i(sel_n), .select_expand_high_i(exp_hi),
      .select_expand_low_n_i(exp_lo_n), .addr_strobe_proc_i(proc_n),
      .addr_strobe_ctrl_i(ctrl_n), .burst_advance_n_i(adv_n), .lane_write_n_i(lane_n),
      .lane_write_gate_n_i(gate_n), .global_write_n_i(glob_n),
      .output_drive_n_i(drive_n), .sleep_request_i(sleep), .burst_order_sel_i(order),
      .output_stage_sel_i(stage), .data_out_o(data_out_o), .data_oe_n_o(data_oe_n_o),
      .power_down_o(power_down_o));
   task automatic check(input string what, input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic wr(input logic [14:0] a, input logic [31:0] d, input logic [3:0] l,
      input logic g, w);
      master.present(1'b1, 1'b0, 1'b1, l, g, w, a, d);
   endtask
   // flow-through read: data stands from the same edge that takes the read
   task automatic rd(input string what, input logic [14:0] a, input logic [31:0] exp);
      master.present(1'b1, 1'b0, 1'b1, 4'hf, 1'b1, 1'b1, a, ~exp);
      master.idle(1'b1);
      #1 check(what, data_out_o, exp);
   endtask
   task automatic s_pass(input logic stg);
      master.idle(1'b1);
      stage <= stg;
      wr(15'h0010, 32'hcafe_f00d, 4'h0, 1'b0, 1'b1);
      master.idle(1'b1);
      #1 check("oe during write", data_oe_n_o, 1);
      master.idle(1'b1);
      #1 check("first oe", data_oe_n_o, stg);
      if (!stg) check("flow data", data_out_o, 32'hcafe_f00d);
      master.idle(1'b1);
      #1 check("data", data_out_o, 32'hcafe_f00d);
      check("oe", data_oe_n_o, 0);
      master.idle(1'b1);
      stage <= 1'b0;
   endtask
   task automatic s_lanes();
      wr(15'h0020, 32'h1111_1111, 4'h0, 1'b0, 1'b1);
      wr(15'h0020, 32'h2222_2222, 4'he, 1'b0, 1'b1);
      wr(15'h0020, 32'h3333_3333, 4'h0, 1'b1, 1'b1);
      rd("lane write", 15'h0020, 32'h1111_1122);
      wr(15'h0020, 32'h4444_4444, 4'hf, 1'b1, 1'b0);
      rd("global write", 15'h0020, 32'h4444_4444);
   endtask
   task automatic s_burst(input logic ord);
      logic [1:0] cnt, low;
      cnt = 2'h0;
      master.idle(1'b1);
      order <= ord;
      for (int i = 0; i < 4; i++) wr(15'h0104 + 15'(i), 32'h0a00 + 32'(i), 4'h0, 1'b0, 1'b1);
      master.present(1'b1, 1'b0, 1'b1, 4'hf, 1'b1, 1'b1, 15'h0105, 32'h0);
      for (int k = 0; k < 6; k++) begin
         master.idle(k == 2);
         low = ord ? (2'h1 ^ cnt) : (2'h1 + cnt);
         #1 check("burst", data_out_o, 32'h0a00 + 32'(low));
         if (k != 2) cnt = cnt + 2'h1;
      end
   endtask
   task automatic s_proc();
      wr(15'h0200, 32'h5555_5555, 4'h0, 1'b0, 1'b1);
      master.present(1'b0, 1'b0, 1'b1, 4'h0, 1'b0, 1'b0, 15'h0200, 32'h6666_6666);
      master.idle(1'b1);
      #1 check("proc load reads", data_out_o, 32'h5555_5555);
      master.proc_write(15'h0200, 32'h7777_7777);
      rd("proc write", 15'h0200, 32'h7777_7777);
      master.present(1'b0, 1'b1, 1'b1, 4'hf, 1'b1, 1'b1, 15'h0020, 32'h0);
      sel_n <= 1'b1;
      master.idle(1'b1);
      #1 check("proc ignored", data_out_o, 32'h7777_7777);
      // primary select must stand through the whole controller load cycle
      wr(15'h0020, 32'h0, 4'hf, 1'b1, 1'b1);
      master.idle(1'b1);
      sel_n <= 1'b0;
      #1 check("ctrl deselect", power_down_o, 1);
      master.present(1'b0, 1'b1, 1'b1, 4'hf, 1'b1, 1'b1, 15'h0020, 32'h0);
      exp_hi <= 1'b0;
      master.idle(1'b1);
      exp_hi <= 1'b1;
      #1 check("proc deselect", power_down_o, 1);
      rd("reselect", 15'h0020, 32'h4444_4444);
   endtask
   // mid-run reset: outputs go to their reset levels, the array keeps its words
   task automatic s_reset();
      master.idle(1'b1);
      reset_i <= 1'b1;
      master.idle(1'b1);
      master.idle(1'b1);
      #1 check("reset data", data_out_o, 32'h0);
      check("reset oe", data_oe_n_o, 1);
      check("reset power", power_down_o, 1);
      master.idle(1'b1);
      reset_i <= 1'b0;
      master.present(1'b1, 1'b0, 1'b1, 4'hf, 1'b1, 1'b1, 15'h0020, 32'h0);
      exp_lo_n <= 1'b1;
      master.idle(1'b1);
      exp_lo_n <= 1'b0;
      #1 check("low select deselect", power_down_o, 1);
      rd("after reset", 15'h0020, 32'h4444_4444);
   endtask
   task automatic s_drive_sleep();
      master.idle(1'b1);
      drive_n <= 1'b1;
      master.idle(1'b1);
      drive_n <= 1'b0;
      #1 check("oe released", data_oe_n_o, 1);
      master.idle(1'b1);
      sleep <= 1'b1;
      #1 check("oe back", data_oe_n_o, 0);
      for (int n = 0; n < 4 && power_down_o !== 1'b1; n++) begin
         master.idle(1'b1);
         #1;
      end
      check("sleep", power_down_o, 1);
      if (power_down_o !== 1'b1) results();
      check("sleep oe", data_oe_n_o, 1);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      reset_i <= 1'b0;
      sel_n <= 1'b0;
      exp_hi <= 1'b1;
      exp_lo_n <= 1'b0;
      s_pass(1'b0);
      s_pass(1'b1);
      s_lanes();
      s_burst(1'b0);
      s_burst(1'b1);
      s_proc();
      s_reset();
      s_drive_sleep();
      results();
   end
endmodule
`default_nettype wire
